// *** hw/checksum_regs.vh ***
// register offsets, field positions, reset values and counts for the configuration checksum block
`ifndef CHECKSUM_REGS_VH
`define CHECKSUM_REGS_VH

`define CHK_ADDR_CHECKSUM    16'he532
`define CHK_ADDR_STATUS_ONE  16'he503
`define CHK_ADDR_ENABLE_ONE  16'he50b
`define CHK_FLAG_BIT         25
`define CHK_RESET_VALUE      32'h6bf87803
`define CHK_LFSR_PRESET      32'hffffffff
`define CHK_POLY             32'h04c11db7
`define CHK_IMAGE_BITS       2400
`define CHK_LAST_INDEX       12'd2399

`endif

// *** hw/config_checksum_crc32.v ***
// configuration checksum: continuous crc32 over the configuration image, change flag and interrupt
`include "checksum_regs.vh"

// How it works
// - read-only 32-bit checksum register at e532
// - image covers configuration and reserved registers
// - crc uses the ethernet 32-bit polynomial
// - bits enter lsb first, register by register
// - shift state preset to all ones first
// - feedback steps 2400 times, final state stored
// - after any reset checksum reads default constant
// - write or silent change sets flag bit 25
// - enabled flag drives interrupt line one low
// - writing one clears flag, releases interrupt line
module config_checksum_crc32 (
  input  wire                        clock,
  input  wire                        reset,
  input  wire                        soft_reset,
  input  wire [`CHK_IMAGE_BITS-1:0]  config_image,
  input  wire                        config_write,
  input  wire                        reg_wr,
  input  wire                        reg_rd,
  input  wire [15:0]                 reg_addr,
  input  wire [31:0]                 reg_wdata,
  output reg  [31:0]                 reg_rdata,
  output reg                         interrupt_line_one_n
);

  localparam [1:0] st_preset = 2'd0;
  localparam [1:0] st_shift  = 2'd1;
  localparam [1:0] st_store  = 2'd2;

  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [11:0] bit_idx_ff;
  reg  [11:0] nxt_bit_idx;
  reg  [31:0] checksum_ff;
  reg         crc_flag_ff;
  reg         crc_enable_ff;
  reg         wr_pending_ff;
  wire [31:0] lfsr_crc;
  wire        restart;
  wire        lfsr_preset;
  wire        lfsr_step;
  wire        image_bit;
  wire        rd_status;
  wire        rd_enable;
  wire        rd_checksum;
  wire        wr_status;
  wire        wr_enable;
  wire        silent_change;
  wire        flag_set;
  wire        flag_clear;
  reg  [31:0] nxt_rdata;
  wire        in_preset;
  wire        in_shift;
  wire        in_store;

  // exact match of a 16-bit register address
  function addr_hit;
    input [15:0] addr;
    input [15:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // places a one-bit register field at the flag position of a 32-bit word
  function [31:0] flag_field;
    input bit_value;
    begin
      flag_field                = 32'h00000000;
      flag_field[`CHK_FLAG_BIT] = bit_value;
    end
  endfunction

  assign rd_checksum = reg_rd & addr_hit(reg_addr, `CHK_ADDR_CHECKSUM);
  assign rd_status   = reg_rd & addr_hit(reg_addr, `CHK_ADDR_STATUS_ONE);
  assign rd_enable   = reg_rd & addr_hit(reg_addr, `CHK_ADDR_ENABLE_ONE);
  assign wr_status   = reg_wr & addr_hit(reg_addr, `CHK_ADDR_STATUS_ONE);
  assign wr_enable   = reg_wr & addr_hit(reg_addr, `CHK_ADDR_ENABLE_ONE);

  // state decodes shared by the lfsr preset and step controls, the result register and the change detector
  assign in_preset = (state_ff == st_preset);
  assign in_shift  = (state_ff == st_shift);
  assign in_store  = (state_ff == st_store);

  // a write mid-pass would mix old and new bits, so the pass starts over
  assign restart     = config_write | soft_reset;
  assign lfsr_preset = restart | in_preset;
  assign lfsr_step   = ~restart & in_shift;
  assign image_bit   = config_image[bit_idx_ff];

  crc32_serial_lfsr u_lfsr (
    .clock    (clock),
    .reset    (reset),
    .preset   (lfsr_preset),
    .step     (lfsr_step),
    .data_bit (image_bit),
    .crc      (lfsr_crc)
  );

  always @* begin
    nxt_state   = state_ff;
    nxt_bit_idx = bit_idx_ff;
    case (state_ff)
      st_preset: begin
        nxt_bit_idx = 12'h000;
        nxt_state   = st_shift;
      end
      st_shift: begin
        if (bit_idx_ff == `CHK_LAST_INDEX) begin
          nxt_state = st_store;
        end else begin
          nxt_bit_idx = bit_idx_ff + 12'h001;
        end
      end
      st_store: begin
        nxt_state = st_preset;
      end
      default: begin
        nxt_state = st_preset;
      end
    endcase
    // restart overrides whatever the sequencer was doing
    if (restart) begin
      nxt_state   = st_preset;
      nxt_bit_idx = 12'h000;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_ff   <= st_preset;
      bit_idx_ff <= 12'h000;
    end else begin
      state_ff   <= nxt_state;
      bit_idx_ff <= nxt_bit_idx;
    end
  end

  // only a finished pass reaches the readable register
  // soft reset shows the default constant until the next pass over the live image
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      checksum_ff <= `CHK_RESET_VALUE;
    end else if (soft_reset) begin
      checksum_ff <= `CHK_RESET_VALUE;
    end else if (in_store) begin
      checksum_ff <= lfsr_crc;
    end
  end

  // first pass after reset and any pass after a write are expected to differ
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_pending_ff <= 1'b1;
    end else if (restart) begin
      wr_pending_ff <= 1'b1;
    end else if (in_store) begin
      wr_pending_ff <= 1'b0;
    end
  end

  // a drift is caught only at the end of a pass, up to two passes after it happens
  assign silent_change = in_store & ~wr_pending_ff & (lfsr_crc != checksum_ff);
  assign flag_set      = config_write | silent_change;
  assign flag_clear    = wr_status & reg_wdata[`CHK_FLAG_BIT];

  // set beats clear so an event in the clearing cycle survives
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      crc_flag_ff <= 1'b0;
    end else if (flag_set) begin
      crc_flag_ff <= 1'b1;
    end else if (soft_reset | flag_clear) begin
      crc_flag_ff <= 1'b0;
    end
  end

  // enable keeps only the flag bit; other written bits are dropped
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      crc_enable_ff <= 1'b0;
    end else if (soft_reset) begin
      crc_enable_ff <= 1'b0;
    end else if (wr_enable) begin
      crc_enable_ff <= reg_wdata[`CHK_FLAG_BIT];
    end
  end

  // pin comes from a flip-flop, so it trails the flag by one cycle
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      interrupt_line_one_n <= 1'b1;
    end else begin
      interrupt_line_one_n <= ~(crc_flag_ff & crc_enable_ff);
    end
  end

  // status and enable show only the flag bit; the rest read as zero
  always @* begin
    nxt_rdata = 32'h00000000;
    if (rd_checksum) begin
      nxt_rdata = checksum_ff;
    end else if (rd_status) begin
      nxt_rdata = flag_field(crc_flag_ff);
    end else if (rd_enable) begin
      nxt_rdata = flag_field(crc_enable_ff);
    end
  end

  // unmapped reads return zero; writes to the checksum are ignored
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end
  end

endmodule

// *** hw/crc32_serial_lfsr.v ***
// serial lfsr that folds one data bit per step into a 32-bit crc state
`include "checksum_regs.vh"

module crc32_serial_lfsr (
  input  wire        clock,
  input  wire        reset,
  input  wire        preset,
  input  wire        step,
  input  wire        data_bit,
  output wire [31:0] crc
);

  localparam [31:0] poly = `CHK_POLY;

  reg  [31:0] state_ff;
  wire [31:0] nxt_state;
  wire        feedback;

  assign feedback = data_bit ^ state_ff[31];
  assign nxt_state[0] = feedback & poly[0];

  genvar i;
  generate
    for (i = 1; i < 32; i = i + 1) begin : g_tap
      assign nxt_state[i] = (feedback & poly[i]) ^ state_ff[i-1];
    end
  endgenerate

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_ff <= `CHK_LFSR_PRESET;
    end else if (preset) begin
      state_ff <= `CHK_LFSR_PRESET;
    end else if (step) begin
      state_ff <= nxt_state;
    end
  end

  assign crc = state_ff;

endmodule

// *** tb/checksum_sva.sv ***
// port assertions for the configuration checksum block
`include "checksum_regs.vh"
module checksum_sva (
  input logic        clock,
  input logic        reset,
  input logic        soft_reset,
  input logic        config_write,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic [31:0] reg_rdata,
  input logic        interrupt_line_one_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic st, en, mapped;
  assign st = reg_addr == `CHK_ADDR_STATUS_ONE;
  assign en = reg_addr == `CHK_ADDR_ENABLE_ONE;
  assign mapped = st || en || reg_addr == `CHK_ADDR_CHECKSUM;
  unmapped_read_a: assert property (reg_rd && !mapped |=> reg_rdata == 0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  status_bits_a: assert property (reg_rd && st |=> (reg_rdata & 32'hfdffffff) == 0)
    else $error("status shows bits other than the flag");
  enable_bits_a: assert property (reg_rd && en |=> (reg_rdata & 32'hfdffffff) == 0)
    else $error("enable shows bits other than the flag");
  flag_clear_a: assert property (reg_wr && st && reg_wdata[25] && !config_write ##1 !config_write |=>
    interrupt_line_one_n) else $error("interrupt still low after clear");
  soft_irq_a: assert property (soft_reset |-> ##2 interrupt_line_one_n)
    else $error("interrupt low after software reset");
  reset_out_a: assert property ($fell(reset) |-> interrupt_line_one_n && reg_rdata == 0)
    else $error("outputs wrong after reset");
  write_flag_a: assert property (config_write ##1 !reg_wr && !soft_reset ##1 reg_rd && st |=> reg_rdata[25])
    else $error("flag not set after configuration write");
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the configuration checksum block
`include "checksum_regs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] cs = `CHK_ADDR_CHECKSUM, st = `CHK_ADDR_STATUS_ONE, en = `CHK_ADDR_ENABLE_ONE;
  localparam logic [31:0] fl = 32'h02000000, dflt = 32'h6bf87803;
  logic          clock = 0, reset = 1, soft_reset = 0, config_write = 0, reg_wr = 0, reg_rd = 0;
  logic [15:0]   reg_addr = 0;
  logic [31:0]   reg_wdata = 0, reg_rdata;
  localparam logic [2399:0] img_a = {75{32'ha5c30f17}}, img_b = {75{32'h1e2d3c4b}};
  logic [2399:0] config_image = img_a;
  logic          interrupt_line_one_n;
  int            err_total = 0, check_count = 0;
  always #5 clock = ~clock;
  config_checksum_crc32 config_checksum_crc32_i (.clock(clock), .reset(reset), .soft_reset(soft_reset),
    .config_image(config_image), .config_write(config_write), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .interrupt_line_one_n(interrupt_line_one_n));
  function automatic logic [31:0] crc_of(input logic [2399:0] im);
    logic [31:0] b;
    b = 32'hffffffff;
    for (int j = 0; j < 2400; j++) b = {b[30:0], 1'b0} ^ ({32{im[j] ^ b[31]}} & 32'h04c11db7);
    return b;
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 0;
    @(negedge clock);
    `CHK(reg_rdata, e)
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    idle(3);
    reset <= 0;
    rd(cs, dflt);
    rd(16'h1234, 0);
    wr(cs, 0);
    rd(cs, dflt);
    idle(2500);
    rd(cs, crc_of(img_a));
    rd(st, 0);
    wr(en, fl);
    rd(en, fl);
    @(posedge clock);
    config_image <= img_b;
    config_write <= 1;
    @(posedge clock);
    config_write <= 0;
    rd(st, fl);
    `CHK(interrupt_line_one_n, 1'b0)
    rd(cs, crc_of(img_a));
    wr(st, fl);
    idle(1);
    @(negedge clock);
    `CHK(interrupt_line_one_n, 1'b1)
    rd(st, 0);
    idle(2500);
    rd(cs, crc_of(img_b));
    rd(st, 0);
    // image drifts with no write: must be caught as a silent change
    @(posedge clock);
    config_image <= img_a;
    idle(5000);
    rd(st, fl);
    `CHK(interrupt_line_one_n, 1'b0)
    rd(cs, crc_of(img_a));
    // recovery after a silent change: software reset, then reprogram
    @(posedge clock);
    soft_reset <= 1;
    @(posedge clock);
    soft_reset <= 0;
    rd(cs, dflt);
    rd(en, 0);
    `CHK(interrupt_line_one_n, 1'b1)
    wr(en, fl);
    @(posedge clock);
    config_write <= 1;
    @(posedge clock);
    config_write <= 0;
    rd(st, fl);
    `CHK(interrupt_line_one_n, 1'b0)
    // hardware reset mid-run drops flag, enable and read data
    @(posedge clock);
    reset <= 1;
    @(posedge clock);
    reset <= 0;
    @(negedge clock);
    `CHK(reg_rdata, 32'h00000000)
    `CHK(interrupt_line_one_n, 1'b1)
    rd(cs, dflt);
    rd(st, 0);
    rd(en, 0);
    wrap_up;
  end
endmodule
bind config_checksum_crc32 checksum_sva checksum_sva_i (.clock(clock), .reset(reset), .soft_reset(soft_reset),
  .config_write(config_write), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .interrupt_line_one_n(interrupt_line_one_n));
